// ---- port_pins_pkg.sv ----
`default_nettype none
package port_pins_pkg;
   // Bus and data widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int J_W = 2;
   localparam int J_LO = 6;
   typedef logic [7:0] idx_t;
   typedef logic [DATA_W-1:0] byte_t;
   // Register indices, byte address is four times the index
   localparam idx_t IDX_T_DIR = 8'h02;
   localparam idx_t IDX_S_DIR = 8'h0A;
   localparam idx_t IDX_M_DIR = 8'h12;
   localparam idx_t IDX_P_DATA = 8'h18;
   localparam idx_t IDX_P_INPUT = 8'h19;
   localparam idx_t IDX_P_DIR = 8'h1A;
   localparam idx_t IDX_P_DRIVE = 8'h1B;
   localparam idx_t IDX_P_EDGE = 8'h1D;
   localparam idx_t IDX_P_IRQ_EN = 8'h1E;
   localparam idx_t IDX_P_IRQ_FLAGS = 8'h1F;
   localparam idx_t IDX_J_IRQ_EN = 8'h2E;
   localparam idx_t IDX_J_IRQ_FLAGS = 8'h2F;
   localparam idx_t IDX_MISC_CFG = 8'h30;
   localparam idx_t IDX_PRIO = 8'h31;
   localparam idx_t IDX_EV_STATUS = 8'h32;
   localparam idx_t IDX_EV_MASK = 8'h33;
   // Reset values
   localparam byte_t RST_BYTE = 8'h00;
   localparam byte_t RST_MISC = 8'h03;
   // Field positions in the misc configuration register
   localparam int MISC_S_PULL = 0;
   localparam int MISC_M_PULL = 1;
   localparam int MISC_T_PULL = 2;
   localparam int MISC_S_WOR = 3;
   localparam int MISC_M_WOR = 4;
   // Event status bits
   localparam int EV_P = 0;
   localparam int EV_J = 1;
   // Vectors and elevation codes
   localparam logic [15:0] VEC_NONE = 16'h0000;
   localparam logic [15:0] VEC_P = 16'hFF8E;
   localparam logic [15:0] VEC_J = 16'hFFCE;
   localparam byte_t ELEV_P = 8'h8E;
   localparam byte_t ELEV_J = 8'hCE;
endpackage
`default_nettype wire

// ---- reg_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
   import port_pins_pkg::*;
   idx_t idx;
   byte_t wdata;
   logic cap;
   logic wr;
   logic rd;
   byte_t rdata;
   logic err;
   modport bus (output idx, wdata, cap, wr, rd, input rdata, err);
   modport regs (input idx, wdata, cap, wr, rd, output rdata, err);
endinterface
`default_nettype wire

// ---- apb_reg_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module apb_reg_slave (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // APB
   input wire logic [port_pins_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Register side
   reg_bus_if.bus rb
);
   import port_pins_pkg::*;
   logic aligned;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_prdata;

   // Decode and strobes; write and read side effects at the completion edge
   always_comb begin
      aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
      rb.idx = paddr[9:2];
      rb.wdata = pwdata[DATA_W-1:0];
      rb.cap = psel && penable && !pready;
      rb.wr = psel && penable && pready && pwrite && aligned && !pslverr;
      rb.rd = psel && penable && pready && !pwrite && aligned && !pslverr;
      next_pready = rb.cap;
      next_pslverr = rb.cap ? (!aligned || rb.err) : 1'b0;
      next_prdata = prdata;
      if (rb.cap && !pwrite && aligned && !rb.err) begin
         next_prdata = {24'h000000, rb.rdata};
      end else if (rb.cap) begin
         next_prdata = 32'h00000000;
      end
   end

   // One wait state on every access
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

// ---- pin_sync_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Pins and edge selection
   input wire logic [W-1:0] pins,
   input wire logic [W-1:0] rise_sel,
   // Filtered level and edge pulses
   output logic [W-1:0] level,
   output logic [W-1:0] edge_seen
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   // Level moves only once stages two and three agree
   always_comb begin
      next_level = (s2 & s3) | (level & (s2 ^ s3));
      edge_seen = (rise_sel & ~level & next_level) | (~rise_sel & level & ~next_level);
   end

   // Three-stage synchroniser
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         level <= '0;
      end else begin
         s1 <= pins;
         s2 <= s1;
         s3 <= s2;
         level <= next_level;
      end
   end
endmodule
`default_nettype wire

// ---- port_integration_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_integration_pins (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // APB
   input wire logic [port_pins_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port P pins
   input wire logic [7:0] port_p_in,
   output logic [7:0] port_p_out,
   output logic [7:0] port_p_oe_n,
   output logic [7:0] port_p_reduced,
   // Port J pins 7:6
   input wire logic [port_pins_pkg::J_W-1:0] port_j_in,
   // Ports T, S and M configuration
   output logic [7:0] port_t_dir,
   output logic [7:0] port_s_dir,
   output logic [7:0] port_m_dir,
   output logic port_t_pull,
   output logic port_s_pull,
   output logic port_m_pull,
   output logic port_s_wired_or,
   output logic port_m_wired_or,
   // CPU side
   input wire logic cpu_i_mask,
   output logic irq_port_p,
   output logic irq_port_j,
   output logic [15:0] irq_vector,
   output logic irq_elevated,
   output logic wake_req,
   output logic event_irq
);
   import port_pins_pkg::*;

   reg_bus_if rb ();
   logic rst_q1;
   logic rst_n_sync;
   byte_t p_level;
   byte_t p_edge;
   logic [J_W-1:0] j_level;
   logic [J_W-1:0] j_edge;
   byte_t p_data, next_p_data;
   byte_t p_dir, next_p_dir;
   byte_t p_drive, next_p_drive;
   byte_t p_rise, next_p_rise;
   byte_t p_en, next_p_en;
   byte_t p_flags, next_p_flags;
   logic [J_W-1:0] j_rise, next_j_rise;
   logic [J_W-1:0] j_en, next_j_en;
   logic [J_W-1:0] j_flags, next_j_flags;
   byte_t t_dir, next_t_dir;
   byte_t s_dir, next_s_dir;
   byte_t m_dir, next_m_dir;
   byte_t misc, next_misc;
   byte_t prio, next_prio;
   logic [1:0] ev, next_ev;
   logic [1:0] ev_mask, next_ev_mask;
   logic [1:0] ev_snap, next_ev_snap;
   logic p_req, j_req;
   logic [15:0] next_vector;
   logic next_elevated;
   byte_t p_readback;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_q1 <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n_sync <= rst_q1;
      end
   end

   apb_reg_slave u_apb (
      .core_clk(core_clk),
      .rst_n(rst_n_sync),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rb(rb)
   );

   pin_sync_edge #(.W(DATA_W)) u_sync_p (
      .core_clk(core_clk),
      .rst_n(rst_n_sync),
      .pins(port_p_in),
      .rise_sel(p_rise),
      .level(p_level),
      .edge_seen(p_edge)
   );

   pin_sync_edge #(.W(J_W)) u_sync_j (
      .core_clk(core_clk),
      .rst_n(rst_n_sync),
      .pins(port_j_in),
      .rise_sel(j_rise),
      .level(j_level),
      .edge_seen(j_edge)
   );

   // Output pins show latch, input pins show synchronised level
   assign p_readback = (p_dir & p_data) | (~p_dir & p_level);

   // Register read mux and unmapped detection
   always_comb begin
      rb.rdata = RST_BYTE;
      rb.err = 1'b0;
      if (rb.idx == IDX_P_DATA) begin
         rb.rdata = p_readback;
      end else if (rb.idx == IDX_P_INPUT) begin
         rb.rdata = p_level;
      end else if (rb.idx == IDX_P_DIR) begin
         rb.rdata = p_dir;
      end else if (rb.idx == IDX_P_DRIVE) begin
         rb.rdata = p_drive;
      end else if (rb.idx == IDX_P_EDGE) begin
         rb.rdata = p_rise;
      end else if (rb.idx == IDX_P_IRQ_EN) begin
         rb.rdata = p_en;
      end else if (rb.idx == IDX_P_IRQ_FLAGS) begin
         rb.rdata = p_flags;
      end else if (rb.idx == IDX_J_IRQ_EN) begin
         rb.rdata = {j_en, 6'h00};
      end else if (rb.idx == IDX_J_IRQ_FLAGS) begin
         rb.rdata = {j_flags, 6'h00};
      end else if (rb.idx == IDX_T_DIR) begin
         rb.rdata = t_dir;
      end else if (rb.idx == IDX_S_DIR) begin
         rb.rdata = s_dir;
      end else if (rb.idx == IDX_M_DIR) begin
         rb.rdata = m_dir;
      end else if (rb.idx == IDX_MISC_CFG) begin
         rb.rdata = misc;
      end else if (rb.idx == IDX_PRIO) begin
         rb.rdata = prio;
      end else if (rb.idx == IDX_EV_STATUS) begin
         rb.rdata = {6'h00, ev};
      end else if (rb.idx == IDX_EV_MASK) begin
         rb.rdata = {6'h00, ev_mask};
      end else begin
         rb.err = 1'b1;
      end
   end

   // Next state of registers, flags and interrupt outputs
   always_comb begin
      next_p_data = p_data;
      next_p_dir = p_dir;
      next_p_drive = p_drive;
      next_p_rise = p_rise;
      next_p_en = p_en;
      next_j_rise = j_rise;
      next_j_en = j_en;
      next_t_dir = t_dir;
      next_s_dir = s_dir;
      next_m_dir = m_dir;
      next_misc = misc;
      next_prio = prio;
      next_ev_mask = ev_mask;
      if (rb.wr) begin
         if (rb.idx == IDX_P_DATA) begin
            next_p_data = rb.wdata;
         end else if (rb.idx == IDX_P_DIR) begin
            next_p_dir = rb.wdata;
         end else if (rb.idx == IDX_P_DRIVE) begin
            next_p_drive = rb.wdata;
         end else if (rb.idx == IDX_P_EDGE) begin
            next_p_rise = rb.wdata;
         end else if (rb.idx == IDX_P_IRQ_EN) begin
            next_p_en = rb.wdata;
         end else if (rb.idx == IDX_J_IRQ_EN) begin
            next_j_en = rb.wdata[DATA_W-1:J_LO];
         end else if (rb.idx == IDX_T_DIR) begin
            next_t_dir = rb.wdata;
         end else if (rb.idx == IDX_S_DIR) begin
            next_s_dir = rb.wdata;
         end else if (rb.idx == IDX_M_DIR) begin
            next_m_dir = rb.wdata;
         end else if (rb.idx == IDX_MISC_CFG) begin
            next_misc = rb.wdata;
         end else if (rb.idx == IDX_PRIO) begin
            next_prio = rb.wdata;
         end else if (rb.idx == IDX_EV_MASK) begin
            next_ev_mask = rb.wdata[1:0];
         end
      end
      // Port J edge polarity shares the port P polarity bits 7:6
      next_j_rise = next_p_rise[DATA_W-1:J_LO];
      // Sticky flags, write one clears, a new edge wins
      next_p_flags = p_flags;
      next_j_flags = j_flags;
      if (rb.wr && rb.idx == IDX_P_IRQ_FLAGS) begin
         next_p_flags = p_flags & ~rb.wdata;
      end
      if (rb.wr && rb.idx == IDX_J_IRQ_FLAGS) begin
         next_j_flags = j_flags & ~rb.wdata[DATA_W-1:J_LO];
      end
      next_p_flags = next_p_flags | p_edge;
      next_j_flags = next_j_flags | j_edge;
      // Event status, cleared by reading only the bits that were reported
      next_ev_snap = ev_snap;
      if (rb.cap && rb.idx == IDX_EV_STATUS) begin
         next_ev_snap = ev;
      end
      next_ev = ev;
      if (rb.rd && rb.idx == IDX_EV_STATUS) begin
         next_ev = ev & ~ev_snap;
      end
      next_ev[EV_P] = next_ev[EV_P] | (|p_edge);
      next_ev[EV_J] = next_ev[EV_J] | (|j_edge);
      // Separate requests per port, gated by local enables; CPU mask applied only at the irq outputs
      p_req = |(p_flags & p_en);
      j_req = |(j_flags & j_en);
      // Elevated source first, otherwise J outranks P
      next_vector = VEC_NONE;
      next_elevated = 1'b0;
      if (p_req && prio == ELEV_P) begin
         next_vector = VEC_P;
         next_elevated = 1'b1;
      end else if (j_req && prio == ELEV_J) begin
         next_vector = VEC_J;
         next_elevated = 1'b1;
      end else if (j_req) begin
         next_vector = VEC_J;
      end else if (p_req) begin
         next_vector = VEC_P;
      end
   end

   // Register state; reset values give inputs, full drive, interrupts off
   always_ff @(posedge core_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         p_data <= RST_BYTE;
         p_dir <= RST_BYTE;
         p_drive <= RST_BYTE;
         p_rise <= RST_BYTE;
         p_en <= RST_BYTE;
         p_flags <= RST_BYTE;
         j_rise <= '0;
         j_en <= '0;
         j_flags <= '0;
         t_dir <= RST_BYTE;
         s_dir <= RST_BYTE;
         m_dir <= RST_BYTE;
         misc <= RST_MISC;
         prio <= RST_BYTE;
         ev <= 2'b00;
         ev_mask <= 2'b00;
         ev_snap <= 2'b00;
      end else begin
         p_data <= next_p_data;
         p_dir <= next_p_dir;
         p_drive <= next_p_drive;
         p_rise <= next_p_rise;
         p_en <= next_p_en;
         p_flags <= next_p_flags;
         j_rise <= next_j_rise;
         j_en <= next_j_en;
         j_flags <= next_j_flags;
         t_dir <= next_t_dir;
         s_dir <= next_s_dir;
         m_dir <= next_m_dir;
         misc <= next_misc;
         prio <= next_prio;
         ev <= next_ev;
         ev_mask <= next_ev_mask;
         ev_snap <= next_ev_snap;
      end
   end

   // Pin and interrupt outputs, each from its own flop
   always_ff @(posedge core_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         port_p_out <= RST_BYTE;
         port_p_oe_n <= 8'hFF;
         port_p_reduced <= RST_BYTE;
         port_t_dir <= RST_BYTE;
         port_s_dir <= RST_BYTE;
         port_m_dir <= RST_BYTE;
         port_t_pull <= RST_MISC[MISC_T_PULL];
         port_s_pull <= RST_MISC[MISC_S_PULL];
         port_m_pull <= RST_MISC[MISC_M_PULL];
         port_s_wired_or <= RST_MISC[MISC_S_WOR];
         port_m_wired_or <= RST_MISC[MISC_M_WOR];
         irq_port_p <= 1'b0;
         irq_port_j <= 1'b0;
         irq_vector <= VEC_NONE;
         irq_elevated <= 1'b0;
         wake_req <= 1'b0;
         event_irq <= 1'b0;
      end else begin
         port_p_out <= next_p_data;
         port_p_oe_n <= ~next_p_dir;
         port_p_reduced <= next_p_drive & next_p_dir;
         port_t_dir <= next_t_dir;
         port_s_dir <= next_s_dir;
         port_m_dir <= next_m_dir;
         port_t_pull <= next_misc[MISC_T_PULL];
         port_s_pull <= next_misc[MISC_S_PULL];
         port_m_pull <= next_misc[MISC_M_PULL];
         port_s_wired_or <= next_misc[MISC_S_WOR];
         port_m_wired_or <= next_misc[MISC_M_WOR];
         irq_port_p <= p_req && !cpu_i_mask;
         irq_port_j <= j_req && !cpu_i_mask;
         irq_vector <= cpu_i_mask ? VEC_NONE : next_vector;
         irq_elevated <= !cpu_i_mask && next_elevated;
         wake_req <= p_req || j_req;
         event_irq <= |(next_ev & next_ev_mask);
      end
   end

   // Checks
   oe_follows_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      port_p_oe_n == ~p_dir) else $error("output enable differs from direction");
   readback_mux_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      rb.cap && !pwrite && rb.idx == IDX_P_DATA && paddr[1:0] == 2'b00
      && paddr[ADDR_W-1:10] == '0 |=> prdata[7:0] == $past(p_readback))
      else $error("data readback wrong");
   reduced_gated_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      port_p_reduced == (p_drive & p_dir)) else $error("reduced drive on input pin");
   drive_offset_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      psel && penable && pready && pwrite && !pslverr && paddr == {2'b00, IDX_P_DRIVE, 2'b00}
      |=> p_drive == $past(pwdata[7:0])) else $error("drive register write lost");
   reset_ports_a: assert property (@(posedge core_clk)
      $rose(rst_n_sync) |-> p_dir == RST_BYTE && p_en == RST_BYTE && j_en == '0
      && port_p_oe_n == 8'hFF) else $error("interrupt port reset state wrong");
   reset_serial_a: assert property (@(posedge core_clk)
      $rose(rst_n_sync) |-> port_s_pull && port_m_pull && !port_s_wired_or
      && !port_m_wired_or && port_s_dir == RST_BYTE) else $error("serial port reset wrong");
   reset_timer_a: assert property (@(posedge core_clk)
      $rose(rst_n_sync) |-> !port_t_pull && port_t_dir == RST_BYTE)
      else $error("timer port reset wrong");
   irq_p_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      irq_port_p |-> $past(|(p_flags & p_en)) && !$past(cpu_i_mask))
      else $error("port P request without enabled flag");
   irq_j_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      irq_port_j |-> $past(|(j_flags & j_en)) && !$past(cpu_i_mask))
      else $error("port J request without enabled flag");
   elevate_p_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      irq_elevated && irq_vector == VEC_P |-> $past(prio) == ELEV_P)
      else $error("port P elevated without code");
   vector_j_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      irq_port_j && $past(prio) != ELEV_P |-> irq_vector == VEC_J)
      else $error("port J vector wrong");
   wake_on_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      (|(j_flags & j_en)) |=> wake_req) else $error("no wake on enabled flag");
   flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      p_flags[0] && !(rb.wr && rb.idx == IDX_P_IRQ_FLAGS && rb.wdata[0]) |=> p_flags[0])
      else $error("flag lost without clear");
   edge_sets_a: assert property (@(posedge core_clk) disable iff (!rst_n_sync)
      p_edge[0] |=> p_flags[0] ##1 (irq_port_p || !$past(p_en[0]) || $past(cpu_i_mask)))
      else $error("edge did not reach request");
   p_irq_c: cover property (@(posedge core_clk) disable iff (!rst_n_sync) $rose(irq_port_p));
   j_irq_c: cover property (@(posedge core_clk) disable iff (!rst_n_sync) $rose(irq_port_j));
   elev_c: cover property (@(posedge core_clk) disable iff (!rst_n_sync) irq_elevated);
   ev_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n_sync)
      rb.rd && rb.idx == IDX_EV_STATUS && ev != 2'b00);
endmodule
`default_nettype wire

// ---- board_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_pins (
   // Pins from the block
   input wire logic [7:0] port_p_out,
   input wire logic [7:0] port_p_oe_n,
   // Levels set by the board
   input wire logic [7:0] p_level,
   input wire logic [1:0] j_level,
   // Resolved pin levels
   output logic [7:0] port_p_in,
   output logic [1:0] port_j_in
);
   // Driven pins follow the block, the others the board
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         port_p_in[i] = (port_p_oe_n[i] == 1'b0) ? port_p_out[i] : p_level[i];
      end
      port_j_in = j_level;
   end
endmodule
`default_nettype wire

// ---- port_integration_pins_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module port_integration_pins_test;
   import port_pins_pkg::*;
   logic core_clk = 1'b0, reset_n, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cpu_i_mask = 1'b0, pready, pslverr, irq_port_p, irq_port_j, irq_elevated;
   logic wake_req, event_irq, port_t_pull, port_s_pull, port_m_pull;
   logic port_s_wired_or, port_m_wired_or;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] p_out, p_oe_n, p_red, p_in, t_dir, s_dir, m_dir, p_level = 8'hFF;
   logic [1:0] j_in, j_level = 2'b11;
   logic [15:0] irq_vector;
   logic err;
   int num_errors = 0, n_compared = 0;
   // Clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   port_integration_pins uut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_p_in(p_in), .port_p_out(p_out),
      .port_p_oe_n(p_oe_n), .port_p_reduced(p_red), .port_j_in(j_in), .port_t_dir(t_dir),
      .port_s_dir(s_dir), .port_m_dir(m_dir), .port_t_pull(port_t_pull),
      .port_s_pull(port_s_pull), .port_m_pull(port_m_pull),
      .port_s_wired_or(port_s_wired_or), .port_m_wired_or(port_m_wired_or),
      .cpu_i_mask(cpu_i_mask), .irq_port_p(irq_port_p), .irq_port_j(irq_port_j),
      .irq_vector(irq_vector), .irq_elevated(irq_elevated), .wake_req(wake_req),
      .event_irq(event_irq));
   board_pins board (.port_p_out(p_out), .port_p_oe_n(p_oe_n), .p_level(p_level),
      .j_level(j_level), .port_p_in(p_in), .port_j_in(j_in));
   // One APB transfer, held until pready is sampled high
   task automatic apb(input idx_t idx, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      paddr <= {2'b00, idx, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check_reset_state();
      `CHK({t_dir, s_dir, m_dir, p_oe_n, p_red}, 40'h00_0000_FF00)
      `CHK({port_t_pull, port_s_pull, port_m_pull}, 3'b011)
      `CHK({port_s_wired_or, port_m_wired_or, irq_port_p, irq_port_j}, 4'h0)
      apb(IDX_P_DRIVE, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0000)
      apb(IDX_MISC_CFG, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0003)
      apb(IDX_P_IRQ_EN, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0000)
      apb(8'h3F, 1'b0, 8'h00);
      `CHK({err, rd}, 33'h1_0000_0000)
   endtask
   task automatic check_direction_drive();
      apb(IDX_P_DATA, 1'b1, 8'hA5);
      apb(IDX_P_DRIVE, 1'b1, 8'hFF);
      wait_clk(1);
      `CHK(p_red, 8'h00)
      apb(IDX_P_DIR, 1'b1, 8'h0F);
      wait_clk(2);
      `CHK({p_oe_n, p_out, p_red}, 24'hF0_A5_0F)
      apb(IDX_P_INPUT, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_00F5)
      apb(IDX_P_DATA, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_00F5)
      apb(IDX_P_DIR, 1'b1, 8'h00);
      apb(IDX_P_DRIVE, 1'b1, 8'h00);
   endtask
   task automatic check_port_p_irq();
      apb(IDX_P_IRQ_EN, 1'b1, 8'h01);
      p_level <= 8'hFE;
      wait_clk(8);
      `CHK({irq_port_p, wake_req, irq_vector, event_irq}, 19'b1_1_1111111110001110_0)
      apb(IDX_EV_MASK, 1'b1, 8'h03);
      wait_clk(2);
      `CHK(event_irq, 1'b1)
      apb(IDX_EV_STATUS, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0001)
      wait_clk(2);
      `CHK(event_irq, 1'b0)
      cpu_i_mask <= 1'b1;
      wait_clk(3);
      `CHK({irq_port_p, wake_req}, 2'b01)
      cpu_i_mask <= 1'b0;
      apb(IDX_P_IRQ_FLAGS, 1'b1, 8'hFE);
      apb(IDX_P_IRQ_FLAGS, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0001)
   endtask
   task automatic check_port_j_and_priority();
      apb(IDX_J_IRQ_EN, 1'b1, 8'hFF);
      apb(IDX_J_IRQ_EN, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_00C0)
      j_level <= 2'b01;
      wait_clk(8);
      `CHK({irq_port_j, irq_port_p, irq_vector, irq_elevated}, 19'h7_FFCE << 1)
      apb(IDX_J_IRQ_FLAGS, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0080)
      apb(IDX_PRIO, 1'b1, 8'h8E);
      wait_clk(2);
      `CHK({irq_vector, irq_elevated}, 17'h1_FF1D)
      apb(IDX_PRIO, 1'b1, 8'hCE);
      apb(IDX_P_IRQ_FLAGS, 1'b1, 8'h01);
      wait_clk(2);
      `CHK({irq_port_p, irq_vector, irq_elevated}, 18'h1_FF9D)
      apb(IDX_J_IRQ_FLAGS, 1'b1, 8'h80);
      wait_clk(2);
      `CHK({irq_port_j, wake_req, irq_vector}, 18'h0_0000)
   endtask
   task automatic check_config_and_rising();
      apb(IDX_MISC_CFG, 1'b1, 8'h1C);
      apb(IDX_T_DIR, 1'b1, 8'h81);
      apb(IDX_S_DIR, 1'b1, 8'h42);
      apb(IDX_M_DIR, 1'b1, 8'h24);
      wait_clk(1);
      `CHK({t_dir, s_dir, m_dir}, 24'h81_42_24)
      `CHK({port_s_wired_or, port_m_wired_or, port_t_pull}, 3'b111)
      `CHK({port_s_pull, port_m_pull}, 2'b00)
      apb(IDX_P_EDGE, 1'b1, 8'h01);
      p_level <= 8'hFF;
      wait_clk(8);
      `CHK({irq_port_p, irq_vector, irq_elevated}, {1'b1, VEC_P, 1'b0})
      apb(IDX_P_IRQ_FLAGS, 1'b1, 8'h01);
      p_level <= 8'hFE;
      wait_clk(8);
      `CHK({irq_port_p, wake_req}, 2'b00)
      apb(IDX_EV_STATUS, 1'b0, 8'h00);
      `CHK(rd, 32'h0000_0003)
      wait_clk(2);
      `CHK(event_irq, 1'b0)
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      num_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      reset_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      wait_clk(4);
      check_reset_state();
      check_direction_drive();
      check_port_p_irq();
      check_port_j_and_priority();
      check_config_and_rising();
      tally_and_finish();
   end
endmodule
`undef CHK
`default_nettype wire
